// >>> design/qec_counter.sv
// qec_counter: top of the quadrature encoder position counter.
// assumes one 100 MHz clock, encoder lines synchronous to it, active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module qec_counter import qec_pkg::*; #(
  parameter int unsigned CNT_W = QEC_CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // encoder lines
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_i_i,
  // register port
  input wire logic [QEC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // position outputs
  output logic [CNT_W-1:0] count_o,
  output logic index_o,
  output logic [CNT_W-1:0] latch_o,
  output logic latch_valid_o
);

  // reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_n;

  // counter phase: waiting for first index or running
  typedef enum logic [1:0] {
    QEC_ST_WAIT = 2'b01,
    QEC_ST_RUN = 2'b10
  } qec_ph_t;

  // whole state of the counter
  typedef struct packed {
    qec_ph_t ph;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] latch;
    logic lvalid;
    logic idx;
  } qec_ct_st_t;

  qec_ct_st_t st_q;
  qec_ct_st_t st_d;
  qec_cfg_t cfg;
  qec_evt_t evt;
  logic [CNT_W-1:0] max;
  logic rearm;

  // release reset through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // input sync and quadrature decode
  qec_frontend u_fe (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .enc_a_i(enc_a_i),
    .enc_b_i(enc_b_i),
    .enc_i_i(enc_i_i),
    .cfg_i(cfg),
    .evt_o(evt)
  );

  // register file
  qec_regs #(.CNT_W(CNT_W)) u_regs (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .count_i(st_q.cnt),
    .latch_i(st_q.latch),
    .armed_i(st_q.ph == QEC_ST_WAIT),
    .cfg_o(cfg),
    .max_o(max),
    .rearm_o(rearm)
  );

  // count update: the index clear takes priority over a simultaneous step
  always_comb begin
    logic idx_used;
    qec_ph_t ph_now;
    idx_used = 1'b0;
    ph_now = QEC_ST_WAIT;
    st_d = st_q;
    // a rearm pulse clears the phase first, so an index in the same cycle still counts as the first
    ph_now = rearm ? QEC_ST_WAIT : st_q.ph;
    st_d.ph = ph_now;
    // step first so that an index in the same cycle still wins
    if (evt.step) begin
      if (evt.up) begin
        st_d.cnt = (st_q.cnt >= max) ? '0 : st_q.cnt + 1'b1; // see R01 see R04
      end else begin
        st_d.cnt = (st_q.cnt == '0) ? max : st_q.cnt - 1'b1; // see R05
      end
    end
    // free mode never looks at the index line
    idx_used = evt.idx_rise && (cfg.mode != QEC_MODE_FREE); // see R07
    st_d.idx = idx_used; // see R11
    case (cfg.mode)
      QEC_MODE_FREE: begin
        st_d.lvalid = 1'b0; // see R07
      end
      QEC_MODE_CAPTURE: begin
        // latch the count before this cycle's step
        if (idx_used) begin
          st_d.latch = st_q.cnt; // see R08
          st_d.lvalid = 1'b1;
        end
      end
      QEC_MODE_RST_IDX: begin
        st_d.lvalid = 1'b0; // see R09
        if (idx_used) begin
          st_d.cnt = '0; // see R06 see R09
        end
      end
      QEC_MODE_RST_FIRST: begin
        st_d.lvalid = 1'b0;
        case (ph_now)
          QEC_ST_WAIT: begin
            if (idx_used) begin
              st_d.cnt = '0; // see R06 see R10
              st_d.ph = QEC_ST_RUN;
            end
          end
          QEC_ST_RUN: ; // later index pulses leave the count alone, see R10
          default: st_d.ph = QEC_ST_WAIT;
        endcase
      end
      default: st_d.lvalid = 1'b0;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q.ph <= QEC_ST_WAIT;
      st_q.cnt <= '0;
      st_q.latch <= '0;
      st_q.lvalid <= 1'b0;
      st_q.idx <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops; latch valid cleared outside capture mode, latched count still driven on latch_o
  assign count_o = st_q.cnt;
  assign index_o = st_q.idx; // see R11
  assign latch_o = st_q.latch;
  assign latch_valid_o = st_q.lvalid; // see R11

endmodule : qec_counter
`default_nettype wire

// >>> design/qec_frontend.sv
// qec_frontend: synchronises A, B and index and decodes quadrature steps.
// assumes inputs are synchronous to clk_i; the two-stage sync guards metastability anyway.
`timescale 1ns/1ps
`default_nettype none
module qec_frontend import qec_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // encoder lines and configuration
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_i_i,
  input wire qec_cfg_t cfg_i,
  // decoded events
  output qec_evt_t evt_o
);

  // whole state of the front end
  typedef struct packed {
    logic [2:0] s1;   // first sync stage, read only by s2
    logic [2:0] s2;   // second sync stage
    logic [2:0] prev; // previous settled sample
    logic [2:0] fill; // ones shift in after reset; events wait until prev holds a real sample
    qec_evt_t evt;
  } qec_fe_st_t;

  qec_fe_st_t st_q;
  qec_fe_st_t st_d;
  logic [2:0] pin;
  logic [2:0] pol;

  assign pol = {cfg_i.pol_i, cfg_i.pol_b, cfg_i.pol_a}; // see R12
  assign pin = {enc_i_i, enc_b_i, enc_a_i};

  // step decode: with polarity applied an inverted line mirrors direction per channel
  always_comb begin
    logic da;
    logic db;
    logic [2:0] cur;
    da = 1'b0;
    db = 1'b0;
    cur = 3'h0;
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1; // see R14
    st_d.fill = {st_q.fill[1:0], 1'b1};
    cur = st_q.s2 ^ pol; // see R12
    st_d.prev = cur;
    da = cur[0] ^ st_q.prev[0];
    db = cur[1] ^ st_q.prev[1];
    // exactly one channel changed; both changing is an invalid jump
    st_d.evt.step = da ^ db; // see R02 see R14
    // A leads B forward: A change makes A differ from B, B change makes B equal A
    st_d.evt.up = da ? (cur[0] != cur[1]) : (cur[0] == cur[1]); // see R01
    // decoder path drops an index edge that lands on an invalid A/B jump; direct path passes it
    // both paths keep the same latency, so the counter stage needs no alignment
    st_d.evt.idx_rise = cur[2] & ~st_q.prev[2] & (cfg_i.route_direct | ~(da & db)); // see R13
    // no events until prev holds a settled sample, so a line high at reset is not an edge
    if (!st_q.fill[2]) begin
      st_d.evt = '0; // see R14
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign evt_o = st_q.evt;

endmodule : qec_frontend
`default_nettype wire

// >>> design/qec_regs.sv
// qec_regs: register file of the encoder counter on a plain strobe port.
// assumes strobes last one cycle and never coincide; read data valid the cycle after.
`timescale 1ns/1ps
`default_nettype none
module qec_regs import qec_pkg::*; #(
  parameter int unsigned CNT_W = QEC_CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bus port
  input wire logic [QEC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // block state
  input wire logic [CNT_W-1:0] count_i,
  input wire logic [CNT_W-1:0] latch_i,
  input wire logic armed_i,
  output qec_cfg_t cfg_o,
  output logic [CNT_W-1:0] max_o,
  output logic rearm_o
);

  // whole register state
  typedef struct packed {
    logic [31:0] ctrl;
    logic [CNT_W-1:0] max;
    logic [31:0] rdata;
    logic rearm;
  } qec_rf_st_t;

  qec_rf_st_t st_q;
  qec_rf_st_t st_d;

  // decode writes and reads; unmapped addresses read as zero
  always_comb begin
    st_d = st_q;
    st_d.rearm = 1'b0;
    st_d.rdata = 32'h0000_0000;
    if (wr_i) begin
      case (addr_i)
        QEC_OFS_CTRL: begin
          st_d.ctrl = {26'h0, wdata_i[5:0]};
          // writing the arm bit restarts first-index initialisation
          st_d.rearm = wdata_i[QEC_CTRL_ARM];
        end
        QEC_OFS_MAX: st_d.max = wdata_i[CNT_W-1:0]; // see R03
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        QEC_OFS_CTRL: st_d.rdata = st_q.ctrl | ({31'h0, armed_i} << QEC_CTRL_ARM);
        QEC_OFS_MAX: st_d.rdata = 32'(st_q.max);
        QEC_OFS_COUNT: st_d.rdata = 32'(count_i);
        QEC_OFS_LATCH: st_d.rdata = 32'(latch_i);
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q.ctrl <= QEC_CTRL_RST;
      st_q.max <= CNT_W'(QEC_MAX_RST);
      st_q.rdata <= 32'h0000_0000;
      st_q.rearm <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign max_o = st_q.max;
  assign rearm_o = st_q.rearm;
  assign cfg_o.mode = qec_mode_t'(st_q.ctrl[QEC_CTRL_MODE_LO +: 2]);
  assign cfg_o.pol_a = st_q.ctrl[QEC_CTRL_POL_A];
  assign cfg_o.pol_b = st_q.ctrl[QEC_CTRL_POL_B];
  assign cfg_o.pol_i = st_q.ctrl[QEC_CTRL_POL_I];
  assign cfg_o.route_direct = st_q.ctrl[QEC_CTRL_ROUTE];

endmodule : qec_regs
`default_nettype wire

// >>> shared/qec_pkg.sv
// qec_pkg: constants, register map and carrier types of the quadrature encoder counter.
// assumes a single 100 MHz clock domain and a simple address/strobe register port.
// How it works
// R01: count up when B rises after A
// R02: count every edge of A and B
// R03: software sets maximum as lines times four minus one
// R04: forward edge at maximum wraps to zero
// R05: reverse edge at zero loads maximum
// R06: index-reset modes clear count on index rise
// R07: free-running mode ignores index, no index outputs
// R08: capture mode latches count on each index
// R09: reset-by-index clears count, no latched output; latch_o still drives the last captured count, only latch valid is cleared
// R10: first-index mode clears only on first index
// R11: outputs count, index pulse, latched count by mode
// R12: per-channel polarity selects active edge
// R13: index routed via decoder or directly to counter
// R14: synchronise inputs; ignore simultaneous A and B change
package qec_pkg;

  // widths
  localparam int unsigned QEC_CNT_W = 32;
  localparam int unsigned QEC_ADDR_W = 4;

  // register offsets (word aligned byte addresses)
  localparam logic [3:0] QEC_OFS_CTRL = 4'h0;
  localparam logic [3:0] QEC_OFS_MAX = 4'h4;
  localparam logic [3:0] QEC_OFS_COUNT = 4'h8;
  localparam logic [3:0] QEC_OFS_LATCH = 4'hC;

  // control field positions
  localparam int unsigned QEC_CTRL_MODE_LO = 0;
  localparam int unsigned QEC_CTRL_POL_A = 2;
  localparam int unsigned QEC_CTRL_POL_B = 3;
  localparam int unsigned QEC_CTRL_POL_I = 4;
  localparam int unsigned QEC_CTRL_ROUTE = 5;
  localparam int unsigned QEC_CTRL_ARM = 6;

  // reset values
  localparam logic [31:0] QEC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] QEC_MAX_RST = 32'h0000_0FFF;

  // index modes
  typedef enum logic [1:0] {
    QEC_MODE_FREE = 2'h0,
    QEC_MODE_CAPTURE = 2'h1,
    QEC_MODE_RST_IDX = 2'h2,
    QEC_MODE_RST_FIRST = 2'h3
  } qec_mode_t;

  // configuration carried from the register file to the counter
  typedef struct packed {
    qec_mode_t mode;
    logic pol_a;
    logic pol_b;
    logic pol_i;
    logic route_direct;
  } qec_cfg_t;

  // decoded step events from the front end
  typedef struct packed {
    logic step;
    logic up;
    logic idx_rise;
  } qec_evt_t;

endpackage : qec_pkg

// >>> tb/qec_counter_checker.sv
// qec_counter_checker: port assertions of the encoder counter.
// assumes it is bound to qec_counter; pipeline latency is tracked loosely.
`timescale 1ns/1ps
`default_nettype none
module qec_counter_checker import qec_pkg::*; #(
  parameter int unsigned CNT_W = QEC_CNT_W
) (
  // watched ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_i_i,
  input wire logic [QEC_ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [CNT_W-1:0] count_o,
  input wire logic index_o,
  input wire logic [CNT_W-1:0] latch_o,
  input wire logic latch_valid_o
);
  logic [2:0] pv_q; // last encoder lines
  logic [7:0] ab_q; // recent a/b edges or writes, spans the sync pipeline
  logic [7:0] ix_q; // recent index edges or writes
  // writes count too, since a polarity change flips a line inside the block
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pv_q <= 3'h0;
      ab_q <= 8'h00;
      ix_q <= 8'h00;
    end else begin
      pv_q <= {enc_i_i, enc_b_i, enc_a_i};
      ab_q <= {ab_q[6:0], wr_i | (pv_q[1:0] != {enc_b_i, enc_a_i})};
      ix_q <= {ix_q[6:0], wr_i | (pv_q[2] != enc_i_i)};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_cnt_cause: assert property ($changed(count_o) |-> (|ab_q) || (|ix_q))
    else $error("count moved with no edge");
  chk_cnt_step: assert property ($changed(count_o) |->
    count_o == $past(count_o) + 1'b1 || count_o == $past(count_o) - 1'b1 || count_o == '0 || $past(count_o) == '0)
    else $error("count jumped");
  chk_idx_pulse: assert property (index_o |=> !index_o)
    else $error("index pulse too long");
  chk_idx_cause: assert property (index_o |-> |ix_q)
    else $error("index pulse with no index edge");
  chk_valid_rise: assert property ($rose(latch_valid_o) |->
    index_o || $past(index_o) || $past(wr_i) || $past(wr_i, 2))
    else $error("latch valid with no capture");
  chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read");
  chk_rd_count: assert property ($past(rd_i) && $past(addr_i) == QEC_OFS_COUNT |->
    rdata_o == 32'($past(count_o)))
    else $error("count read wrong");
  chk_rd_latch: assert property ($past(rd_i) && $past(addr_i) == QEC_OFS_LATCH |->
    rdata_o == 32'($past(latch_o)))
    else $error("latch read wrong");
  cov_index: cover property (index_o);
  cov_latch: cover property ($rose(latch_valid_o));
  cov_wrap: cover property ($past(count_o) == '0 && count_o > 32'h1);
endmodule : qec_counter_checker
bind qec_counter qec_counter_checker #(.CNT_W(CNT_W)) i_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .enc_i_i(enc_i_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .count_o(count_o), .index_o(index_o), .latch_o(latch_o),
  .latch_valid_o(latch_valid_o));
`default_nettype wire

// >>> tb/qec_counter_test.sv
// qec_counter_test: self-checking bench for the encoder counter.
// assumes the encoder model and the checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
module qec_counter_test import qec_pkg::*;;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic step = 1'b0;
  logic fwd = 1'b0;
  logic bad = 1'b0;
  logic idx = 1'b0;
  logic enc_a;
  logic enc_b;
  logic enc_i;
  logic [31:0] rdata_o;
  logic [31:0] count_o;
  logic index_o;
  logic [31:0] latch_o;
  logic latch_valid_o;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic rd_p = 1'b0; // read strobe of the previous cycle
  logic [31:0] cnt = 32'h0; // expected count
  logic [31:0] mx = 32'h0; // expected maximum
  int error_cnt = 0;
  int check_count = 0;
  int idx_seen = 0; // index pulses seen
  initial forever #5 clk_i = ~clk_i;
  qec_enc_model i_enc (.clk_i(clk_i), .step_i(step), .fwd_i(fwd), .bad_i(bad), .idx_i(idx),
    .a_o(enc_a), .b_o(enc_b), .i_o(enc_i));
  qec_counter #(.CNT_W(32)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .enc_a_i(enc_a),
    .enc_b_i(enc_b), .enc_i_i(enc_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .count_o(count_o), .index_o(index_o), .latch_o(latch_o),
    .latch_valid_o(latch_valid_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_p) begin
      chk(rdata_o, exp_q.pop_front());
    end
    if (index_o === 1'b1) begin
      idx_seen++;
    end
    rd_p = rd_i;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd
  // steps at random spacing, then lets the pipeline settle
  task automatic mv(input logic f, input int n);
    repeat (n) begin
      @(posedge clk_i);
      fwd <= f;
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      repeat ($urandom_range(3, 1)) @(posedge clk_i);
      if (f) cnt = (cnt == mx) ? 32'h0 : cnt + 32'h1;
      else cnt = (cnt == 32'h0) ? mx : cnt - 32'h1;
    end
    repeat (8) @(posedge clk_i);
  endtask : mv
  task automatic ix(input logic v);
    @(posedge clk_i);
    idx <= v;
    repeat (8) @(posedge clk_i);
  endtask : ix
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(24274));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // the counter leaves reset waiting for a first index, so the arm bit reads back set
    rd(QEC_OFS_CTRL, QEC_CTRL_RST | (32'h1 << QEC_CTRL_ARM));
    rd(QEC_OFS_MAX, QEC_MAX_RST);
    rd(4'h2, 32'h0);
    mx = 32'h7; // two line pairs of four edges, minus one
    wr(QEC_OFS_MAX, mx);
    mv(1'b1, 9);
    rd(QEC_OFS_COUNT, cnt);
    mv(1'b0, 2);
    rd(QEC_OFS_COUNT, cnt);
    @(posedge clk_i);
    bad <= 1'b1;
    @(posedge clk_i);
    bad <= 1'b0;
    mv(1'b1, 1);
    rd(QEC_OFS_COUNT, cnt);
    ix(1'b1);
    ix(1'b0);
    chk(idx_seen, 0);
    rd(QEC_OFS_COUNT, cnt);
    wr(QEC_OFS_CTRL, 32'h1);
    mv(1'b1, 3);
    ix(1'b1);
    ix(1'b0);
    rd(QEC_OFS_LATCH, cnt);
    rd(QEC_OFS_COUNT, cnt);
    chk({31'h0, latch_valid_o}, 32'h1);
    chk(idx_seen, 1);
    wr(QEC_OFS_CTRL, 32'h2);
    repeat (2) begin
      mv(1'b1, 2);
      ix(1'b1);
      ix(1'b0);
      cnt = 32'h0;
      rd(QEC_OFS_COUNT, cnt);
    end
    chk({31'h0, latch_valid_o}, 32'h0);
    wr(QEC_OFS_CTRL, 32'h43);
    rd(QEC_OFS_CTRL, 32'h43);
    mv(1'b1, 2);
    ix(1'b1);
    ix(1'b0);
    cnt = 32'h0;
    rd(QEC_OFS_CTRL, 32'h3);
    mv(1'b1, 3);
    ix(1'b1);
    ix(1'b0);
    rd(QEC_OFS_COUNT, cnt);
    // inverted lines set in free mode first, so the switch itself clears nothing
    wr(QEC_OFS_CTRL, 32'h3C);
    wr(QEC_OFS_CTRL, 32'h3E);
    mv(1'b1, 2);
    ix(1'b1);
    rd(QEC_OFS_COUNT, cnt);
    ix(1'b0);
    cnt = 32'h0;
    rd(QEC_OFS_COUNT, cnt);
    finish_test();
  end
endmodule : qec_counter_test
`default_nettype wire

// >>> tb/qec_enc_model.sv
// qec_enc_model: behavioural incremental encoder with A, B and index lines.
// assumes one-cycle step and fault requests from the bench on the system clock.
`timescale 1ns/1ps
`default_nettype none
module qec_enc_model (
  // requests
  input wire logic clk_i,
  input wire logic step_i, // one quarter phase
  input wire logic fwd_i, // direction of that step
  input wire logic bad_i, // fault: both channels flip at once
  input wire logic idx_i, // index level asked for
  // encoder lines
  output logic a_o,
  output logic b_o,
  output logic i_o
);
  logic [1:0] ph_q = 2'h0; // gray phase 00, A, AB, B
  logic i_q = 1'b0; // index line
  // forward lets A lead, so B rises after A
  always_ff @(posedge clk_i) begin
    if (step_i) begin
      ph_q <= fwd_i ? ph_q + 2'h1 : ph_q - 2'h1;
    end else if (bad_i) begin
      ph_q <= ph_q + 2'h2;
    end
    i_q <= idx_i;
  end
  assign a_o = ph_q[1] ^ ph_q[0];
  assign b_o = ph_q[1];
  assign i_o = i_q;
endmodule : qec_enc_model
`default_nettype wire
